// *** asf_adder.sv ***
`timescale 1ns/1ps
module asf_adder #(
    parameter int WIDTH = 8
) (
    input  wire logic       [WIDTH-1:0] a,
    input  wire logic       [WIDTH-1:0] b,
    input  wire logic                   sub,
    input  wire asf_pkg::asf_op_t       op,
    input  wire logic                   carry_in,
    asf_res_if.src                      res
);
    logic [WIDTH-1:0] b_eff;
    logic [WIDTH:0]   sum;
    logic [asf_pkg::NIBBLE_W:0] low_sum;

    // Subtraction adds the two's complement of the second operand.
    always_comb begin
        b_eff   = sub ? ~b : b;
        sum     = {1'b0, a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, sub};
        low_sum = {1'b0, a[asf_pkg::NIBBLE_W-1:0]}
                + {1'b0, b_eff[asf_pkg::NIBBLE_W-1:0]}
                + {{asf_pkg::NIBBLE_W{1'b0}}, sub};
    end

    // Result and carries; a carry out of a two's complement add is an inverted borrow.
    always_comb begin
        res.nibble = low_sum[asf_pkg::NIBBLE_W];
        res.carry  = sum[WIDTH];
        res.result = sum[WIDTH-1:0];
        if (op == asf_pkg::ASF_OP_ROT_RIGHT) begin
            res.result = {carry_in, a[WIDTH-1:1]};
            res.carry  = a[0];
        end else if (op == asf_pkg::ASF_OP_ROT_LEFT) begin
            res.result = {a[WIDTH-2:0], carry_in};
            res.carry  = a[WIDTH-1];
        end
        res.zero = (res.result == '0);
    end
endmodule

// *** asf_pkg.sv ***
package asf_pkg;

    // ****************************************************************
    // Register map and field layout.
    // ****************************************************************
    localparam logic [8:0] STATUS_ADDR_B0 = 9'h003;
    localparam logic [8:0] STATUS_ADDR_B1 = 9'h083;
    localparam logic [8:0] STATUS_ADDR_B2 = 9'h103;
    localparam logic [8:0] STATUS_ADDR_B3 = 9'h183;
    localparam logic [6:0] STATUS_LOW_ADDR = 7'h03;
    localparam int         BIT_CARRY   = 0;
    localparam int         BIT_NIBBLE  = 1;
    localparam int         BIT_ZERO    = 2;
    localparam int         BIT_SLEEP   = 3;
    localparam int         BIT_WDOG    = 4;
    localparam int         NIBBLE_W    = 4;
    localparam logic [2:0] BANK_RESET  = 3'h0;
    localparam logic [2:0] ARITH_RESET = 3'h0;
    localparam logic       SLEEP_RESET = 1'b1;
    localparam logic       WDOG_RESET  = 1'b1;

    // ****************************************************************
    // Operation codes presented by the instruction decoder.
    // ****************************************************************
    typedef enum logic [3:0] {
        ASF_OP_NONE       = 4'h0,
        ASF_OP_ADD        = 4'h1,
        ASF_OP_SUB        = 4'h2,
        ASF_OP_ROT_RIGHT  = 4'h3,
        ASF_OP_ROT_LEFT   = 4'h4,
        ASF_OP_LOGIC      = 4'h5,
        ASF_OP_MOVE_Z     = 4'h6,
        ASF_OP_SLEEP      = 4'h7,
        ASF_OP_WDT_CLEAR  = 4'h8
    } asf_op_t;

endpackage

// *** asf_res_if.sv ***
`timescale 1ns/1ps
// Carries the adder outputs from the flag datapath to the status register.
interface asf_res_if;
    logic [7:0] result;
    logic       carry;
    logic       nibble;
    logic       zero;
    modport src (output result, output carry, output nibble, output zero);
    modport dst (input result, input carry, input nibble, input zero);
endinterface

// *** asf_status.sv ***
`timescale 1ns/1ps
// Functional notes
// - Digit flag set on carry from bit three.
// - Digit flag updated by the two add/sub operations.
// - Digit flag is inverted borrow on subtract.
// - Carry flag set on carry out of bit seven.
// - Carry flag is inverted borrow on subtract.
// - Subtract adds the second operand's two's complement.
// - Rotates load carry with the shifted-out bit.
// - Status register mirrored at 03h, 83h, 103h, 183h.
// - Flag-affecting ops override writes to arithmetic flags.
// - Watchdog and sleep flags ignore software writes.
module asf_status (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire asf_pkg::asf_op_t op,
    input  wire logic       [7:0] operand_a,
    input  wire logic       [7:0] operand_b,
    input  wire logic       [7:0] logic_result,
    input  wire logic             wdt_timeout,
    input  wire logic       [8:0] addr,
    input  wire logic       [7:0] wdata,
    input  wire logic             wr_en,
    input  wire logic             rd_en,
    output logic            [7:0] rdata,
    output logic            [7:0] alu_result,
    output logic            [7:0] status_flags
);

    // ****************************************************************
    // Datapath.
    // ****************************************************************
    asf_res_if res_bus ();
    logic [2:0] bank_reg;
    logic       wdog_reg;
    logic       sleep_reg;
    logic       zero_reg;
    logic       nibble_reg;
    logic       carry_reg;
    logic       sel;
    logic       arith;
    logic       rotate;
    logic       flag_op;
    logic [7:0] status_now;

    asf_adder #(
        .WIDTH    (8)
    ) u_adder (
        .a        (operand_a),
        .b        (operand_b),
        .sub      (op == asf_pkg::ASF_OP_SUB),
        .op       (op),
        .carry_in (carry_reg),
        .res      (res_bus)
    );

    // Decode of the instruction classes that touch flags.
    always_comb begin
        arith   = (op == asf_pkg::ASF_OP_ADD) || (op == asf_pkg::ASF_OP_SUB);
        rotate  = (op == asf_pkg::ASF_OP_ROT_RIGHT) || (op == asf_pkg::ASF_OP_ROT_LEFT);
        flag_op = arith || rotate || (op == asf_pkg::ASF_OP_LOGIC)
               || (op == asf_pkg::ASF_OP_MOVE_Z);
        sel     = (addr[6:0] == asf_pkg::STATUS_LOW_ADDR);
        alu_result = (op == asf_pkg::ASF_OP_LOGIC) ? logic_result : res_bus.result;
    end

    // ****************************************************************
    // Status register.
    // ****************************************************************

    // Bank select bits are plain read/write.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bank_reg <= asf_pkg::BANK_RESET;
        end else if (wr_en && sel) begin
            bank_reg <= wdata[7:5];
        end
    end

    // Zero flag: result logic has priority over a software write.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            zero_reg <= asf_pkg::ARITH_RESET[asf_pkg::BIT_ZERO];
        end else if (arith || op == asf_pkg::ASF_OP_LOGIC) begin
            zero_reg <= (alu_result == 8'h00);
        end else if (op == asf_pkg::ASF_OP_MOVE_Z) begin
            zero_reg <= (operand_a == 8'h00);
        end else if (wr_en && sel && !flag_op) begin
            zero_reg <= wdata[asf_pkg::BIT_ZERO];
        end
    end

    // Digit flag: only add and subtract update it.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            nibble_reg <= asf_pkg::ARITH_RESET[asf_pkg::BIT_NIBBLE];
        end else if (arith) begin
            nibble_reg <= res_bus.nibble;
        end else if (wr_en && sel && !flag_op) begin
            nibble_reg <= wdata[asf_pkg::BIT_NIBBLE];
        end
    end

    // Carry flag: add, subtract and rotates update it.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            carry_reg <= asf_pkg::ARITH_RESET[asf_pkg::BIT_CARRY];
        end else if (arith || rotate) begin
            carry_reg <= res_bus.carry;
        end else if (wr_en && sel && !flag_op) begin
            carry_reg <= wdata[asf_pkg::BIT_CARRY];
        end
    end

    // Sleep and watchdog flags change only by events, never by writes.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sleep_reg <= asf_pkg::SLEEP_RESET;
            wdog_reg  <= asf_pkg::WDOG_RESET;
        end else if (op == asf_pkg::ASF_OP_WDT_CLEAR) begin
            sleep_reg <= 1'b1;
            wdog_reg  <= 1'b1;
        end else if (op == asf_pkg::ASF_OP_SLEEP) begin
            sleep_reg <= 1'b0;
            wdog_reg  <= 1'b1;
        end else if (wdt_timeout) begin
            wdog_reg  <= 1'b0;
        end
    end

    // Read port answers one cycle after the strobe; other addresses read zero.
    always_comb begin
        status_now = {bank_reg, wdog_reg, sleep_reg, zero_reg, nibble_reg, carry_reg};
        status_flags = status_now;
    end

    // Read data stand for one cycle after a status read and are zero otherwise.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_en && sel) begin
            rdata <= status_now;
        end else begin
            rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    a_carry_add: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_ADD |=> carry_reg == (({1'b0, $past(operand_a)}
            + {1'b0, $past(operand_b)}) > 9'h0FF))
        else $error("carry wrong after add");
    a_borrow_sub: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_SUB |=> carry_reg == ($past(operand_a) >= $past(operand_b)))
        else $error("carry wrong after subtract");
    a_digit_sub: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_SUB |=>
            nibble_reg == ($past(operand_a[3:0]) >= $past(operand_b[3:0])))
        else $error("digit flag wrong after subtract");
    a_digit_add: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_ADD |=> nibble_reg == (({1'b0, $past(operand_a[3:0])}
            + {1'b0, $past(operand_b[3:0])}) > 5'h0F))
        else $error("digit flag wrong after add");
    a_rotate_right: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_ROT_RIGHT |=> carry_reg == $past(operand_a[0]))
        else $error("rotate right carry wrong");
    a_rotate_left: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_ROT_LEFT |=> carry_reg == $past(operand_a[7]))
        else $error("rotate left carry wrong");
    a_digit_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rotate || op == asf_pkg::ASF_OP_LOGIC) |=> $stable(nibble_reg))
        else $error("digit flag changed by other op");
    a_flags_ro: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == asf_pkg::ASF_OP_NONE && !wdt_timeout) |=> $stable(sleep_reg) && $stable(wdog_reg))
        else $error("read-only flag written");
    a_sleep_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_SLEEP |=> !sleep_reg)
        else $error("sleep flag not cleared");
    a_zero_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_LOGIC |=> zero_reg == ($past(logic_result) == 8'h00))
        else $error("zero flag wrong");
    a_mirror_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == asf_pkg::STATUS_ADDR_B3) |=> rdata == $past(status_now))
        else $error("mirror read wrong");
    a_write_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_en && sel && op == asf_pkg::ASF_OP_ADD) |=> carry_reg == $past(res_bus.carry))
        else $error("write not blocked");

    // Steps shared by the write-blocking, bank and read-port checks below.
    sequence s_status_write;
        wr_en && sel;
    endsequence
    sequence s_rotate_write;
        rotate && wr_en && sel;
    endsequence
    sequence s_status_read;
        rd_en && sel;
    endsequence

    a_rotate_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_rotate_write |=> $stable(zero_reg) && $stable(nibble_reg))
        else $error("rotate let a flag write through");
    a_flags_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_status_write ##0 (!wdt_timeout && op != asf_pkg::ASF_OP_SLEEP
            && op != asf_pkg::ASF_OP_WDT_CLEAR) |=> $stable(sleep_reg) && $stable(wdog_reg))
        else $error("read-only flag took a write");
    a_move_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_MOVE_Z |=> zero_reg == ($past(operand_a) == 8'h00))
        else $error("zero flag wrong after move");
    a_wdt_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op == asf_pkg::ASF_OP_WDT_CLEAR |=> sleep_reg && wdog_reg)
        else $error("watchdog restart left a flag low");
    a_bank_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_status_write |=> status_flags[7:5] == $past(wdata[7:5]))
        else $error("bank bits not written");
    a_read_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_status_read |=> rdata == $past(status_now))
        else $error("read data wrong");
    a_read_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(rd_en && sel) |=> rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule

// *** test_alu_status_flags.sv ***
`timescale 1ns/1ps
module test_alu_status_flags;
    // ****************************************************************
    // Stimulus, observed outputs and the expected-status model.
    // ****************************************************************
    logic             ref_clk      = 1'b0;
    logic             rst_n        = 1'b0;
    asf_pkg::asf_op_t op           = asf_pkg::ASF_OP_NONE;
    logic [7:0]       operand_a    = 8'h00;
    logic [7:0]       operand_b    = 8'h00;
    logic [7:0]       logic_result = 8'h00;
    logic             wdt_timeout  = 1'b0;
    logic [8:0]       addr         = 9'h000;
    logic [7:0]       wdata        = 8'h00;
    logic             wr_en        = 1'b0;
    logic             rd_en        = 1'b0;
    logic [7:0]       rdata;
    logic [7:0]       alu_result;
    logic [7:0]       status_flags;
    logic [7:0]       st           = 8'h18;
    logic [7:0]       kn           = 8'hFF;
    int               err_count    = 0;
    int               compares     = 0;
    int               seed         = 12;

    // The clock toggles every 2.5 ns, a period of 5 ns.
    always #2.5 ref_clk = ~ref_clk;

    asf_status i_asf_status (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .op           (op),
        .operand_a    (operand_a),
        .operand_b    (operand_b),
        .logic_result (logic_result),
        .wdt_timeout  (wdt_timeout),
        .addr         (addr),
        .wdata        (wdata),
        .wr_en        (wr_en),
        .rd_en        (rd_en),
        .rdata        (rdata),
        .alu_result   (alu_result),
        .status_flags (status_flags)
    );

    // ****************************************************************
    // Expectation functions and bus tasks.
    // ****************************************************************
    // Returns the carry-out and 8-bit result; subtract adds the inverse plus one.
    function automatic logic [8:0] alu_exp(input asf_pkg::asf_op_t o, input logic [7:0] a,
                                           input logic [7:0] b, input logic ci);
        case (o)
            asf_pkg::ASF_OP_ADD: return {1'b0, a} + {1'b0, b};
            asf_pkg::ASF_OP_SUB: return {1'b0, a} + {1'b0, ~b} + 9'h001;
            asf_pkg::ASF_OP_ROT_RIGHT: return {a[0], ci, a[7:1]};
            asf_pkg::ASF_OP_ROT_LEFT: return {a[7], a[6:0], ci};
            default: return 9'h000;
        endcase
    endfunction

    // Compares the bits selected by the mask; unknowns never match.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        compares++;
        if ((got & m) !== (exp & m)) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Runs one instruction cycle, optionally with a register write, then checks flags.
    task automatic cyc(input asf_pkg::asf_op_t o, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] lr, input logic w, input logic [8:0] ad,
                       input logic [7:0] d, input logic t);
        logic [8:0] s;
        logic [8:0] n;
        s = alu_exp(o, a, b, st[0]);
        n = alu_exp(o, {a[3:0], 4'h0}, {b[3:0], 4'h0}, 1'b0);
        @(posedge ref_clk);
        op <= o;
        operand_a <= a;
        operand_b <= b;
        logic_result <= lr;
        wr_en <= w;
        addr <= ad;
        wdata <= d;
        wdt_timeout <= t;
        #1;
        if (o inside {[asf_pkg::ASF_OP_ADD:asf_pkg::ASF_OP_ROT_LEFT]}) begin
            chk(alu_result, s[7:0], 8'hFF);
        end
        if (w && ad[6:0] == 7'h03) begin
            st[7:5] = d[7:5];
            if (!(o inside {[asf_pkg::ASF_OP_ADD:asf_pkg::ASF_OP_MOVE_Z]})) begin
                st[2:0] = d[2:0];
                kn = 8'hFF;
            end
        end
        case (o)
            asf_pkg::ASF_OP_ADD, asf_pkg::ASF_OP_SUB: begin
                st[2:0] = {s[7:0] == 8'h00, n[8], s[8]};
                kn = 8'hFF;
            end
            asf_pkg::ASF_OP_ROT_RIGHT, asf_pkg::ASF_OP_ROT_LEFT: begin
                st[0] = s[8];
            end
            asf_pkg::ASF_OP_LOGIC: {kn[2], st[2]} = {1'b1, lr == 8'h00};
            asf_pkg::ASF_OP_MOVE_Z: {kn[2], st[2]} = {1'b1, a == 8'h00};
            asf_pkg::ASF_OP_SLEEP: st[4:3] = 2'b10;
            asf_pkg::ASF_OP_WDT_CLEAR: st[4:3] = 2'b11;
            default: ;
        endcase
        if (t) st[4] = 1'b0;
        @(posedge ref_clk);
        op <= asf_pkg::ASF_OP_NONE;
        wr_en <= 1'b0;
        wdt_timeout <= 1'b0;
        #1;
        chk(status_flags, st, kn);
    endtask

    // Reads one address; the data stand in the cycle after the strobe.
    task automatic rd(input logic [8:0] ad);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= ad;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, (ad[6:0] == 7'h03) ? st : 8'h00, (ad[6:0] == 7'h03) ? kn : 8'hFF);
        @(posedge ref_clk);
        #1;
        chk(rdata, 8'h00, 8'hFF);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence: reset, corner cases, random traffic, mirror reads.
    // ****************************************************************
    initial begin
        automatic logic [15:0] cs [6] = '{16'h0F01, 16'hF010, 16'h0000,
                                          16'hFFFF, 16'h1001, 16'h0510};
        asf_pkg::asf_op_t o;
        logic [8:0]       ad;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk(status_flags, 8'h18, 8'hFF);
        rd(9'h003);
        $display("test reset done");
        foreach (cs[i]) begin
            cyc(asf_pkg::ASF_OP_ADD, cs[i][15:8], cs[i][7:0], 8'h00, 1'b0, 9'h000, 8'h00, 1'b0);
            cyc(asf_pkg::ASF_OP_SUB, cs[i][15:8], cs[i][7:0], 8'h00, 1'b0, 9'h000, 8'h00, 1'b0);
        end
        cyc(asf_pkg::ASF_OP_ADD, 8'h0F, 8'h01, 8'h00, 1'b1, 9'h183, 8'hE5, 1'b0);
        cyc(asf_pkg::ASF_OP_NONE, 8'h00, 8'h00, 8'h00, 1'b1, 9'h083, 8'hE7, 1'b0);
        cyc(asf_pkg::ASF_OP_SLEEP, 8'h00, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 1'b0);
        cyc(asf_pkg::ASF_OP_NONE, 8'h00, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 1'b1);
        cyc(asf_pkg::ASF_OP_WDT_CLEAR, 8'h00, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 1'b0);
        cyc(asf_pkg::ASF_OP_LOGIC, 8'h00, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 1'b0);
        cyc(asf_pkg::ASF_OP_ROT_RIGHT, 8'h01, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 1'b0);
        cyc(asf_pkg::ASF_OP_ROT_LEFT, 8'h80, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 1'b0);
        cyc(asf_pkg::ASF_OP_ROT_LEFT, 8'h00, 8'h00, 8'h00, 1'b1, 9'h103, 8'h00, 1'b0);
        $display("test corner done");
        repeat (300) begin
            o = asf_pkg::asf_op_t'(4'(unsigned'($random(seed)) % 9));
            ad = {2'($random(seed)), (($random(seed) & 1) != 0) ? 7'h03 : 7'h13};
            cyc(o, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)) & 8'h03,
                1'($random(seed)), ad, 8'($random(seed)),
                (o == asf_pkg::ASF_OP_NONE) && (($random(seed) & 3) == 0));
        end
        $display("test random done");
        for (int i = 0; i < 4; i++) rd({2'(i), 7'h03});
        rd(9'h004);
        $display("test bus done");
        conclude;
    end
endmodule
